// [inc/pulse_acc_pkg.sv]
package pulse_acc_pkg;
	// Register byte offsets on the APB bus
	localparam logic [7:0] OFS_CONTROL = 8'h00;
	localparam logic [7:0] OFS_COUNT = 8'h04;
	localparam logic [7:0] OFS_MASK = 8'h08;
	localparam logic [7:0] OFS_FLAG = 8'h0C;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int COUNT_W = 8;
	// Control register field positions
	localparam int CTL_ENABLE_BIT = 6;
	localparam int CTL_GATED_BIT = 5;
	localparam int CTL_EDGE_BIT = 4;
	localparam int CTL_CCS_BIT = 2;
	// Mask and flag register shared layout
	localparam int OVF_BIT = 5;
	localparam int EDGE_BIT = 4;
	// Reset values
	localparam logic RST_ENABLE = 1'b0;
	localparam logic RST_GATED = 1'b0;
	localparam logic RST_EDGE = 1'b0;
	localparam logic RST_CCS = 1'b0;
	localparam logic RST_MASK = 1'b0;
	localparam logic RST_FLAG = 1'b0;
	// Gated time base divisor in bus clock cycles
	localparam int TIMEBASE_DIV = 64;
endpackage : pulse_acc_pkg

// [verilog/pulse_event_accumulator.sv]
// The address map and the APB register port were decided locally.
`timescale 1ns/1ps

//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - 8-bit counter, event or gated mode
// - Gated mode counts divide-by-64 ticks while active
// - Enable bit switches accumulator off or on
// - Event mode edge select: falling or rising
// - Gated mode edge select picks inhibiting level
// - Select bit picks compare five or capture four
// - Count register accessible at any time
// - Reset leaves count register unchanged
// - Increments and reads in opposite half cycles
// - Overflow flag on wrap, cleared writing one
// - Overflow enable gates interrupt, not flag
// - Edge flag on selected edge, write-one clears
// - Edge enable gates interrupt, not flag
// - Mask bit gates same-position flag bit
// - Flag register bits 3..0 read zero
module pulse_event_accumulator #(
	parameter int TIMEBASE_DIV = pulse_acc_pkg::TIMEBASE_DIV
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [pulse_acc_pkg::ADDR_W-1:0] paddr,
	input wire logic [pulse_acc_pkg::DATA_W-1:0] pwdata,
	output logic [pulse_acc_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	// Accumulator input pin
	input wire logic accumulator_input_pin,
	// Interrupt and function selects
	output logic irq,
	output logic fifth_output_compare_en,
	output logic fourth_input_capture_en
);
	localparam int PS_W = $clog2(TIMEBASE_DIV);

	// Refused at elaboration; the prescaler wraps only on a power of two
	if (TIMEBASE_DIV < 2 || (TIMEBASE_DIV & (TIMEBASE_DIV - 1)) != 0) begin : g_bad_div
		$error("TIMEBASE_DIV must be a power of two of at least 2");
	end

	typedef struct packed {
		logic pin_d;
		logic phase_two_clock;
		logic [PS_W-1:0] prescale;
		logic inc_pend;
		logic accumulator_enable;
		logic gated_mode_select;
		logic edge_select;
		logic capture_compare_select;
		logic overflow_irq_enable;
		logic input_edge_irq_enable;
		logic overflow_flag;
		logic input_edge_flag;
		logic [pulse_acc_pkg::COUNT_W-1:0] accumulator_count;
		logic [pulse_acc_pkg::DATA_W-1:0] prdata;
		logic pready;
		logic pslverr;
		logic irq;
		logic oc5_en;
		logic ic4_en;
	} acc_state_s;

	acc_state_s st_r;
	acc_state_s st_nxt;

	logic rise;
	logic fall;
	logic sel_edge;
	logic tick;
	logic gate_open;
	logic event_hit;
	logic apply_inc;
	logic done;
	logic wr_ctl;
	logic wr_cnt;
	logic wr_mask;
	logic wr_flag;
	logic ovf_set;
	logic edge_set;
	logic mapped;
	logic [pulse_acc_pkg::DATA_W-1:0] rd_word;

	//////////////////////////////////////////////////////////////////////////
	// Event decode from the pin, sampled on the bus clock
	assign rise = accumulator_input_pin & ~st_r.pin_d;
	assign fall = ~accumulator_input_pin & st_r.pin_d;
	// Trailing edge of a gate equals the selected edge in both modes
	assign sel_edge = st_r.edge_select ? rise : fall;
	assign tick = (st_r.prescale == PS_W'(TIMEBASE_DIV - 1));
	// Gate is inhibited when the pin equals edge_select
	assign gate_open = (accumulator_input_pin != st_r.edge_select);
	always_comb begin
		if (!st_r.accumulator_enable) begin
			event_hit = 1'b0;
		end else if (st_r.gated_mode_select) begin
			event_hit = tick & gate_open;
		end else begin
			event_hit = sel_edge;
		end
	end
	// Pending count lands only on the phase-two cycle
	assign apply_inc = st_r.inc_pend & st_r.phase_two_clock;

	//////////////////////////////////////////////////////////////////////////
	// APB decode; transfers complete only on the non-phase-two cycle
	assign done = psel & penable & st_r.pready;
	assign wr_ctl = done & pwrite & (paddr == pulse_acc_pkg::OFS_CONTROL);
	assign wr_cnt = done & pwrite & (paddr == pulse_acc_pkg::OFS_COUNT);
	assign wr_mask = done & pwrite & (paddr == pulse_acc_pkg::OFS_MASK);
	assign wr_flag = done & pwrite & (paddr == pulse_acc_pkg::OFS_FLAG);
	assign mapped = (paddr == pulse_acc_pkg::OFS_CONTROL) || (paddr == pulse_acc_pkg::OFS_COUNT)
		|| (paddr == pulse_acc_pkg::OFS_MASK) || (paddr == pulse_acc_pkg::OFS_FLAG);
	assign ovf_set = apply_inc & ~wr_cnt & (&st_r.accumulator_count);
	assign edge_set = st_r.accumulator_enable & sel_edge;

	// Read mux; unused and unimplemented bits read zero
	always_comb begin
		rd_word = '0;
		unique case (paddr)
			pulse_acc_pkg::OFS_CONTROL: begin
				rd_word[pulse_acc_pkg::CTL_ENABLE_BIT] = st_r.accumulator_enable;
				rd_word[pulse_acc_pkg::CTL_GATED_BIT] = st_r.gated_mode_select;
				rd_word[pulse_acc_pkg::CTL_EDGE_BIT] = st_r.edge_select;
				rd_word[pulse_acc_pkg::CTL_CCS_BIT] = st_r.capture_compare_select;
			end
			pulse_acc_pkg::OFS_COUNT: begin
				rd_word[pulse_acc_pkg::COUNT_W-1:0] = st_r.accumulator_count;
			end
			pulse_acc_pkg::OFS_MASK: begin
				rd_word[pulse_acc_pkg::OVF_BIT] = st_r.overflow_irq_enable;
				rd_word[pulse_acc_pkg::EDGE_BIT] = st_r.input_edge_irq_enable;
			end
			pulse_acc_pkg::OFS_FLAG: begin
				// Bits 3..0 stay zero
				rd_word[pulse_acc_pkg::OVF_BIT] = st_r.overflow_flag;
				rd_word[pulse_acc_pkg::EDGE_BIT] = st_r.input_edge_flag;
			end
			default: begin
				rd_word = '0;
			end
		endcase
	end

	//////////////////////////////////////////////////////////////////////////
	// Next-state logic for the whole block
	always_comb begin
		st_nxt = st_r;
		st_nxt.pin_d = accumulator_input_pin;
		st_nxt.phase_two_clock = ~st_r.phase_two_clock;
		// Free-running time base, never stopped by the enable
		st_nxt.prescale = st_r.prescale + PS_W'(1);
		// Max input rate is clock/2, so one pending slot suffices
		if (event_hit) begin
			st_nxt.inc_pend = 1'b1;
		end else if (apply_inc) begin
			st_nxt.inc_pend = 1'b0;
		end
		if (wr_cnt) begin
			// Written value wins, queued increment is dropped
			st_nxt.accumulator_count = pwdata[pulse_acc_pkg::COUNT_W-1:0];
			st_nxt.inc_pend = 1'b0;
		end else if (apply_inc) begin
			st_nxt.accumulator_count = st_r.accumulator_count + 8'h01;
		end
		if (wr_ctl) begin
			st_nxt.accumulator_enable = pwdata[pulse_acc_pkg::CTL_ENABLE_BIT];
			st_nxt.gated_mode_select = pwdata[pulse_acc_pkg::CTL_GATED_BIT];
			st_nxt.edge_select = pwdata[pulse_acc_pkg::CTL_EDGE_BIT];
			st_nxt.capture_compare_select = pwdata[pulse_acc_pkg::CTL_CCS_BIT];
		end
		if (wr_mask) begin
			st_nxt.overflow_irq_enable = pwdata[pulse_acc_pkg::OVF_BIT];
			st_nxt.input_edge_irq_enable = pwdata[pulse_acc_pkg::EDGE_BIT];
		end
		// Write-one clears; a same-cycle set wins so no event is lost
		if (wr_flag && pwdata[pulse_acc_pkg::OVF_BIT]) begin
			st_nxt.overflow_flag = 1'b0;
		end
		if (ovf_set) begin
			st_nxt.overflow_flag = 1'b1;
		end
		if (wr_flag && pwdata[pulse_acc_pkg::EDGE_BIT]) begin
			st_nxt.input_edge_flag = 1'b0;
		end
		if (edge_set) begin
			st_nxt.input_edge_flag = 1'b1;
		end
		// Enables only gate the request, never the flags
		st_nxt.irq = (st_nxt.overflow_flag & st_nxt.overflow_irq_enable)
			| (st_nxt.input_edge_flag & st_nxt.input_edge_irq_enable);
		st_nxt.oc5_en = ~st_nxt.capture_compare_select;
		st_nxt.ic4_en = st_nxt.capture_compare_select;
		// Ready rises so that completion falls opposite the increment edge
		st_nxt.pready = psel & penable & ~st_r.pready & st_r.phase_two_clock;
		st_nxt.pslverr = psel & penable & ~st_r.pready & st_r.phase_two_clock & ~mapped;
		if (psel && penable && !st_r.pready && st_r.phase_two_clock && !pwrite) begin
			st_nxt.prdata = rd_word;
		end else if (!psel) begin
			st_nxt.prdata = '0;
		end
	end

	// State register; the count survives reset untouched
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			st_r <= '0;
			st_r.accumulator_enable <= pulse_acc_pkg::RST_ENABLE;
			st_r.gated_mode_select <= pulse_acc_pkg::RST_GATED;
			st_r.edge_select <= pulse_acc_pkg::RST_EDGE;
			st_r.capture_compare_select <= pulse_acc_pkg::RST_CCS;
			st_r.overflow_irq_enable <= pulse_acc_pkg::RST_MASK;
			st_r.input_edge_irq_enable <= pulse_acc_pkg::RST_MASK;
			st_r.overflow_flag <= pulse_acc_pkg::RST_FLAG;
			st_r.input_edge_flag <= pulse_acc_pkg::RST_FLAG;
			st_r.oc5_en <= 1'b1;
			st_r.accumulator_count <= st_r.accumulator_count;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign prdata = st_r.prdata;
	assign pready = st_r.pready;
	assign pslverr = st_r.pslverr;
	assign irq = st_r.irq;
	assign fifth_output_compare_en = st_r.oc5_en;
	assign fourth_input_capture_en = st_r.ic4_en;

	//////////////////////////////////////////////////////////////////////////
	// Checks
	sequence s_count_write;
		wr_cnt;
	endsequence
	sequence s_gate_shut;
		(st_r.accumulator_enable && st_r.gated_mode_select && !gate_open && !wr_cnt
			&& !st_r.inc_pend) [*3];
	endsequence

	property p_irq_gate;
		@(posedge sys_clk) disable iff (!rstn)
		##1 irq == ((st_r.overflow_flag & st_r.overflow_irq_enable)
			| (st_r.input_edge_flag & st_r.input_edge_irq_enable));
	endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("irq not mask-gated flags");

	property p_ovf_set;
		@(posedge sys_clk) disable iff (!rstn)
		(apply_inc && !wr_cnt && st_r.accumulator_count == 8'hFF)
			|=> (st_r.overflow_flag && st_r.accumulator_count == 8'h00);
	endproperty
	a_ovf_set: assert property (p_ovf_set) else $error("wrap did not set overflow");

	property p_ovf_clear;
		@(posedge sys_clk) disable iff (!rstn)
		(wr_flag && pwdata[pulse_acc_pkg::OVF_BIT] && !ovf_set) |=> !st_r.overflow_flag;
	endproperty
	a_ovf_clear: assert property (p_ovf_clear) else $error("overflow clear failed");

	property p_edge_flag;
		@(posedge sys_clk) disable iff (!rstn)
		(st_r.accumulator_enable && sel_edge) |=> st_r.input_edge_flag;
	endproperty
	a_edge_flag: assert property (p_edge_flag) else $error("edge flag not set");

	property p_masked_quiet;
		@(posedge sys_clk) disable iff (!rstn)
		(!st_r.overflow_irq_enable && !st_r.input_edge_irq_enable) |-> !irq;
	endproperty
	a_masked_quiet: assert property (p_masked_quiet) else $error("irq while masked");

	property p_write_wins;
		@(posedge sys_clk) disable iff (!rstn)
		s_count_write |=> st_r.accumulator_count == $past(pwdata[7:0]) && !st_r.inc_pend;
	endproperty
	a_write_wins: assert property (p_write_wins) else $error("count write lost");

	property p_inc_phase;
		@(posedge sys_clk) disable iff (!rstn)
		($changed(st_r.accumulator_count) && !$past(wr_cnt)) |-> $past(st_r.phase_two_clock);
	endproperty
	a_inc_phase: assert property (p_inc_phase) else $error("increment off phase");

	property p_disabled_hold;
		@(posedge sys_clk) disable iff (!rstn)
		(!st_r.accumulator_enable && !st_r.inc_pend && !wr_cnt)
			|=> $stable(st_r.accumulator_count);
	endproperty
	a_disabled_hold: assert property (p_disabled_hold) else $error("count moved while off");

	property p_reset_keeps;
		@(posedge sys_clk) disable iff (1'b0)
		!rstn |=> $stable(st_r.accumulator_count);
	endproperty
	a_reset_keeps: assert property (p_reset_keeps) else $error("reset changed count");

	property p_gate_shut;
		@(posedge sys_clk) disable iff (!rstn)
		s_gate_shut |=> $stable(st_r.accumulator_count);
	endproperty
	a_gate_shut: assert property (p_gate_shut) else $error("counted while gate shut");

	property p_ccs;
		@(posedge sys_clk) disable iff (!rstn)
		##1 (fourth_input_capture_en == st_r.capture_compare_select)
			&& (fifth_output_compare_en != fourth_input_capture_en);
	endproperty
	a_ccs: assert property (p_ccs) else $error("capture/compare select wrong");

	property p_tick_period;
		@(posedge sys_clk) disable iff (!rstn)
		tick |=> !tick [*7];
	endproperty
	a_tick_period: assert property (p_tick_period) else $error("time base too fast");

	property p_ready_pulse;
		@(posedge sys_clk) disable iff (!rstn)
		pready |=> !pready;
	endproperty
	a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");

	property p_edge_clear;
		@(posedge sys_clk) disable iff (!rstn)
		(wr_flag && pwdata[pulse_acc_pkg::EDGE_BIT] && !edge_set) |=> !st_r.input_edge_flag;
	endproperty
	a_edge_clear: assert property (p_edge_clear) else $error("edge flag clear failed");

	property p_event_pend;
		@(posedge sys_clk) disable iff (!rstn)
		(st_r.accumulator_enable && !st_r.gated_mode_select && sel_edge && !wr_cnt)
			|=> st_r.inc_pend;
	endproperty
	a_event_pend: assert property (p_event_pend) else $error("edge not queued");

	property p_gated_pend;
		@(posedge sys_clk) disable iff (!rstn)
		(st_r.accumulator_enable && st_r.gated_mode_select && tick && gate_open && !wr_cnt)
			|=> st_r.inc_pend;
	endproperty
	a_gated_pend: assert property (p_gated_pend) else $error("gated tick not queued");

	property p_flag_low_zero;
		@(posedge sys_clk) disable iff (!rstn)
		(pready && !pwrite && paddr == pulse_acc_pkg::OFS_FLAG) |-> (prdata[3:0] == 4'h0);
	endproperty
	a_flag_low_zero: assert property (p_flag_low_zero) else $error("flag low bits set");
endmodule : pulse_event_accumulator

// [test/pulse_source.sv]
`timescale 1ns/1ps
////////////////////////////////////////
// Far-side pulse and gate source; changes only just after a rising edge
module pulse_source (
	// Clock
	input wire logic sys_clk,
	// Pin toward the accumulator
	output logic pin
);
	initial pin = 1'b0;
	// Full pulses, each level held w cycles; w of 2 or more keeps the rate legal
	task automatic pulses(input int n, input int w);
		for (int i = 0; i < n; i++) begin
			repeat (w) @(posedge sys_clk);
			pin <= ~pin;
			repeat (w) @(posedge sys_clk);
			pin <= ~pin;
		end
	endtask : pulses
	// Gate level, held until changed again
	task automatic level(input logic v);
		@(posedge sys_clk);
		pin <= v;
	endtask : level
endmodule : pulse_source

// [test/pulse_event_accumulator_bench.sv]
`timescale 1ns/1ps
////////////////////////////////////////
module pulse_event_accumulator_bench;
	localparam int TB_DIV = 8;
	logic sys_clk = 1'b0;
	logic rstn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic pin;
	logic irq;
	logic oc_en;
	logic ic_en;
	logic [31:0] q;
	logic e;
	int n_errors = 0;
	int n_checks = 0;

	// Bus clock, 25 ns
	always #12.5 sys_clk = ~sys_clk;

	pulse_event_accumulator #(.TIMEBASE_DIV(TB_DIV)) uut (.sys_clk(sys_clk), .rstn(rstn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .accumulator_input_pin(pin),
		.irq(irq), .fifth_output_compare_en(oc_en), .fourth_input_capture_en(ic_en));
	pulse_source src (.sys_clk(sys_clk), .pin(pin));

	////////////////////////////////////////
	task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	// One APB transfer; pready sampled at the edge, then released, then one idle edge
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		// Only pready or the watchdog ends this wait
		do begin
			@(posedge sys_clk);
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
	endtask : apb
	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr
	task rd(input string what, input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check(what, q, exp);
	endtask : rd
	task stop_test;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : stop_test

	////////////////////////////////////////
	task t_reset;
		rd("ctl", pulse_acc_pkg::OFS_CONTROL, 32'h0);
		rd("mask", pulse_acc_pkg::OFS_MASK, 32'h0);
		rd("flag", pulse_acc_pkg::OFS_FLAG, 32'h0);
		check("oc_en", {31'h0, oc_en}, 32'h1);
		$display("reset values done");
	endtask : t_reset
	// Rising edges across the wrap, then flags, mask and clears
	task t_event;
		wr(pulse_acc_pkg::OFS_CONTROL, 32'h50);
		wr(pulse_acc_pkg::OFS_COUNT, 32'hFE);
		src.pulses(3, 2);
		repeat (4) @(posedge sys_clk);
		rd("count", pulse_acc_pkg::OFS_COUNT, 32'h01);
		rd("flags", pulse_acc_pkg::OFS_FLAG, 32'h30);
		check("irq off", {31'h0, irq}, 32'h0);
		wr(pulse_acc_pkg::OFS_MASK, 32'h20);
		repeat (2) @(posedge sys_clk);
		check("irq ovf", {31'h0, irq}, 32'h1);
		wr(pulse_acc_pkg::OFS_FLAG, 32'h20);
		rd("clr ovf", pulse_acc_pkg::OFS_FLAG, 32'h10);
		check("irq clr", {31'h0, irq}, 32'h0);
		wr(pulse_acc_pkg::OFS_MASK, 32'h10);
		repeat (2) @(posedge sys_clk);
		check("irq edge", {31'h0, irq}, 32'h1);
		wr(pulse_acc_pkg::OFS_FLAG, 32'h10);
		rd("clr edge", pulse_acc_pkg::OFS_FLAG, 32'h0);
		check("irq none", {31'h0, irq}, 32'h0);
		wr(pulse_acc_pkg::OFS_MASK, 32'h0);
		$display("event mode done");
	endtask : t_event
	// Falling edges count; disabled unit neither counts nor flags
	task t_fall;
		wr(pulse_acc_pkg::OFS_CONTROL, 32'h40);
		wr(pulse_acc_pkg::OFS_COUNT, 32'h10);
		src.pulses(2, 3);
		repeat (4) @(posedge sys_clk);
		rd("fall", pulse_acc_pkg::OFS_COUNT, 32'h12);
		wr(pulse_acc_pkg::OFS_FLAG, 32'h30);
		wr(pulse_acc_pkg::OFS_CONTROL, 32'h0);
		src.pulses(2, 2);
		repeat (4) @(posedge sys_clk);
		rd("off cnt", pulse_acc_pkg::OFS_COUNT, 32'h12);
		rd("off flg", pulse_acc_pkg::OFS_FLAG, 32'h0);
		$display("falling and disable done");
	endtask : t_fall
	// Gate open for exactly ten time-base periods, so exactly ten ticks land
	task t_gated;
		wr(pulse_acc_pkg::OFS_CONTROL, 32'h60);
		wr(pulse_acc_pkg::OFS_COUNT, 32'h0);
		repeat (10 * TB_DIV) @(posedge sys_clk);
		rd("low gate", pulse_acc_pkg::OFS_COUNT, 32'h0);
		src.level(1'b1);
		repeat (10 * TB_DIV - 1) @(posedge sys_clk);
		src.level(1'b0);
		repeat (4) @(posedge sys_clk);
		rd("gated", pulse_acc_pkg::OFS_COUNT, 32'h0A);
		// Pin goes high before the count write so no tick slips in after it
		wr(pulse_acc_pkg::OFS_CONTROL, 32'h70);
		src.level(1'b1);
		wr(pulse_acc_pkg::OFS_COUNT, 32'hA5);
		repeat (10 * TB_DIV) @(posedge sys_clk);
		rd("inhibit", pulse_acc_pkg::OFS_COUNT, 32'hA5);
		src.level(1'b0);
		$display("gated mode done");
	endtask : t_gated
	// Function select, count kept through reset, unmapped address refused
	task t_misc;
		wr(pulse_acc_pkg::OFS_CONTROL, 32'h04);
		repeat (2) @(posedge sys_clk);
		check("ic_en", {30'h0, ic_en, oc_en}, 32'h2);
		wr(pulse_acc_pkg::OFS_COUNT, 32'h5A);
		rstn <= 1'b0;
		repeat (3) @(posedge sys_clk);
		rstn <= 1'b1;
		rd("kept", pulse_acc_pkg::OFS_COUNT, 32'h5A);
		apb(1'b0, 8'h10, 32'h0);
		check("slverr", {31'h0, e}, 32'h1);
		$display("select, reset and unmapped done");
	endtask : t_misc

	// Main sequence
	initial begin
		repeat (3) @(posedge sys_clk);
		rstn <= 1'b1;
		t_reset();
		t_event();
		t_fall();
		t_gated();
		t_misc();
		stop_test();
	end
	// Watchdog well beyond the few hundred cycles the tests need
	initial begin
		repeat (20000) @(posedge sys_clk);
		n_errors++;
		stop_test();
	end
endmodule : pulse_event_accumulator_bench
